// File: hdl/dwsp_pkg.sv
package dwsp_pkg;
    localparam int WORD_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int WIPER_BITS = 10;
    localparam int NV_WORDS = 16;
    localparam logic [3:0] ADDR_WIPER_ONE = 4'h0;
    localparam logic [3:0] ADDR_WIPER_TWO = 4'h1;
    localparam logic [9:0] WIPER_MID = 10'h200;
    localparam logic [9:0] WIPER_MAX = 10'h3FF;
    localparam logic [15:0] NV_WIPER_RESET = 16'h0200;
    localparam logic [15:0] NV_USER_RESET = 16'h0000;
    localparam logic [4:0] LAST_BIT_POS = 5'h17;

    typedef enum logic [3:0] {
        DWSP_NOP, DWSP_RESTORE, DWSP_STORE_WIPER, DWSP_STORE_DATA,
        DWSP_DEC6, DWSP_DEC6_ALL, DWSP_DEC1, DWSP_DEC1_ALL,
        DWSP_RESET_RELOAD, DWSP_READ_NV, DWSP_READ_WIPER, DWSP_WRITE,
        DWSP_INC6, DWSP_INC6_ALL, DWSP_INC1, DWSP_INC1_ALL
    } dwsp_cmd_t;

    localparam int CLK_MHZ = 10;
    localparam int STORE_TIME_US = 25000;
    localparam int RELOAD_TIME_US = 1000;
    localparam int READ_TIME_US = 100;
    localparam int REFRESH_TIME_US = 140;
    localparam int STORE_CYC = STORE_TIME_US * CLK_MHZ;
    localparam int RELOAD_CYC = RELOAD_TIME_US * CLK_MHZ;
    localparam int READ_CYC = READ_TIME_US * CLK_MHZ;
    localparam int REFRESH_CYC = REFRESH_TIME_US * CLK_MHZ;
    localparam int BUSY_BITS = 20;
endpackage

// File: hdl/dwsp_sync.sv
`timescale 1ns/1ps
module dwsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] ff1_r, ff2_r, ff3_r, level_r;
    logic [WIDTH-1:0] level_nxt;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : gen_bit
            // A change counts only once the last two stages agree
            always_comb
            begin
                level_nxt[g] = level_r[g];
                if (ff2_r[g] == ff3_r[g])
                begin
                    level_nxt[g] = ff3_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ff1_r <= INIT;
            ff2_r <= INIT;
            ff3_r <= INIT;
            level_r <= INIT;
        end
        else
        begin
            ff1_r <= async_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule

// File: hdl/dwsp_top.sv
`timescale 1ns/1ps
// What this block does
// - Each rising serial clock edge with chip select low shifts one serial_in bit into the shift register.
// - Words travel most significant bit first in both directions.
// - A word is 24 bits: command, address, then 16 data bits.
// - The shifted command runs only when chip select returns high.
// - Read commands 9 and 10 return readback data on serial_out next frame.
// - Other commands pass the previous input word out for daisy chaining.
// - Address 0 selects wiper_one, address 1 selects wiper_two.
// - Write protect low blocks writes, stores, increments and decrements.
// - Restore and reset_reload_command still reload wipers under write protect.
// - Hardware refresh reloads wiper settings from the nonvolatile store.
// - That reload happens on the refresh strobe's rising transition.
// - While the refresh strobe is low both wipers sit at midscale.
// - Nonvolatile wiper words hold midscale 512 until the user stores.
// - Ready goes low during stores, reload, reads and hardware refresh.
// - During a nonvolatile store no new command takes effect.
module dwsp_top #(
    parameter int STORE_CYCLES = dwsp_pkg::STORE_CYC,
    parameter int RELOAD_CYCLES = dwsp_pkg::RELOAD_CYC
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in,
    input wire logic write_protect_n_in,
    input wire logic hardware_refresh_n_in,
    output logic serial_out_out,
    output logic serial_out_oe_out,
    output logic ready_out,
    output logic [9:0] wiper_one_out,
    output logic [9:0] wiper_two_out
);
    // Link domain: runs only on host clock edges
    logic [23:0] rx_r, rx_nxt;
    logic [4:0] pos_r, pos_nxt;
    logic [7:0] edges_r, edges_nxt;
    // Core-side level, steady while the host clock runs
    logic link_clr_r, link_clr_nxt;

    always_comb
    begin
        rx_nxt = rx_r;
        pos_nxt = pos_r;
        edges_nxt = edges_r;
        if (!chip_select_n_in)
        begin
            rx_nxt = {rx_r[22:0], serial_in};
            pos_nxt = (pos_r == dwsp_pkg::LAST_BIT_POS) ? 5'h00 : pos_r + 5'h01;
            edges_nxt = edges_r + 8'h01;
            // No host clock during reset, so counters start clean in the first frame
            if (link_clr_r)
            begin
                pos_nxt = 5'h00;
                edges_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge serial_clk_in)
    begin
        rx_r <= rx_nxt;
        pos_r <= pos_nxt;
        edges_r <= edges_nxt;
    end

    // Core domain
    logic cs_n_s, wp_n_s, refresh_n_s;

    dwsp_sync #(
        .WIDTH(3),
        .INIT(3'h7)
    ) u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({chip_select_n_in, write_protect_n_in, hardware_refresh_n_in}),
        .level_out({cs_n_s, wp_n_s, refresh_n_s})
    );

    typedef enum logic [1:0] {
        DWSP_IDLE,
        DWSP_BUSY,
        DWSP_REFRESH_LOW
    } dwsp_state_t;

    dwsp_state_t state_r, state_nxt;
    logic cs_prev_r, cs_prev_nxt;
    logic refresh_prev_r, refresh_prev_nxt;
    logic [4:0] last_pos_r, last_pos_nxt;
    logic [7:0] last_edges_r, last_edges_nxt;
    logic [9:0] wiper_r [2];
    logic [9:0] wiper_nxt [2];
    logic [15:0] nv_r [dwsp_pkg::NV_WORDS];
    logic [15:0] nv_nxt [dwsp_pkg::NV_WORDS];
    logic [19:0] busy_cnt_r, busy_cnt_nxt;
    logic [23:0] rb_word_r, rb_word_nxt;
    logic rb_mode_r, rb_mode_nxt;
    logic primed_r, primed_nxt;

    function automatic logic [9:0] step(input logic [9:0] w, input logic [3:0] cmd);
        logic [9:0] r;
        r = w;
        case (cmd)
            dwsp_pkg::DWSP_DEC6, dwsp_pkg::DWSP_DEC6_ALL:
                r = w >> 1;
            dwsp_pkg::DWSP_DEC1, dwsp_pkg::DWSP_DEC1_ALL:
                r = (w == 10'h000) ? w : w - 10'h001;
            dwsp_pkg::DWSP_INC6, dwsp_pkg::DWSP_INC6_ALL:
                r = (w >= dwsp_pkg::WIPER_MID) ? dwsp_pkg::WIPER_MAX : w << 1;
            dwsp_pkg::DWSP_INC1, dwsp_pkg::DWSP_INC1_ALL:
                r = (w == dwsp_pkg::WIPER_MAX) ? w : w + 10'h001;
            default:
                r = w;
        endcase
        return r;
    endfunction

    function automatic logic is_all(input logic [3:0] cmd);
        return cmd inside {dwsp_pkg::DWSP_DEC6_ALL, dwsp_pkg::DWSP_DEC1_ALL,
                           dwsp_pkg::DWSP_INC6_ALL, dwsp_pkg::DWSP_INC1_ALL};
    endfunction

    logic [3:0] cmd, addr;
    logic [15:0] data;
    logic frame_end, frame_ok, ch_ok, ch;

    always_comb
    begin
        // Word is stable here: host clock is idle while chip select is high
        cmd = rx_r[dwsp_pkg::CMD_MSB:dwsp_pkg::CMD_LSB];
        addr = rx_r[dwsp_pkg::ADDR_MSB:dwsp_pkg::ADDR_LSB];
        data = rx_r[dwsp_pkg::DATA_MSB:0];
        ch = (addr == dwsp_pkg::ADDR_WIPER_TWO);
        ch_ok = (addr == dwsp_pkg::ADDR_WIPER_ONE) || ch;
        frame_end = cs_n_s && !cs_prev_r;
        frame_ok = primed_r && (pos_r == last_pos_r) && (edges_r != last_edges_r);

        state_nxt = state_r;
        cs_prev_nxt = cs_n_s;
        refresh_prev_nxt = refresh_n_s;
        last_pos_nxt = last_pos_r;
        last_edges_nxt = last_edges_r;
        wiper_nxt = wiper_r;
        nv_nxt = nv_r;
        busy_cnt_nxt = busy_cnt_r;
        rb_word_nxt = rb_word_r;
        rb_mode_nxt = rb_mode_r;
        primed_nxt = primed_r;
        link_clr_nxt = link_clr_r;

        if (frame_end)
        begin
            last_pos_nxt = pos_r;
            last_edges_nxt = edges_r;
            primed_nxt = 1'b1;
            link_clr_nxt = 1'b0;
        end

        case (state_r)
            DWSP_IDLE:
            begin
                if (frame_end && frame_ok)
                begin
                    rb_mode_nxt = 1'b0;
                    case (cmd)
                        dwsp_pkg::DWSP_RESTORE:
                        begin
                            if (ch_ok)
                            begin
                                wiper_nxt[ch] = nv_r[addr][9:0];
                            end
                        end
                        dwsp_pkg::DWSP_RESET_RELOAD:
                        begin
                            wiper_nxt[0] = nv_r[dwsp_pkg::ADDR_WIPER_ONE][9:0];
                            wiper_nxt[1] = nv_r[dwsp_pkg::ADDR_WIPER_TWO][9:0];
                            busy_cnt_nxt = 20'(RELOAD_CYCLES);
                            state_nxt = DWSP_BUSY;
                        end
                        dwsp_pkg::DWSP_STORE_WIPER:
                        begin
                            if (wp_n_s && ch_ok)
                            begin
                                nv_nxt[addr] = {6'h00, wiper_r[ch]};
                                busy_cnt_nxt = 20'(STORE_CYCLES);
                                state_nxt = DWSP_BUSY;
                            end
                        end
                        dwsp_pkg::DWSP_STORE_DATA:
                        begin
                            if (wp_n_s)
                            begin
                                nv_nxt[addr] = data;
                                busy_cnt_nxt = 20'(STORE_CYCLES);
                                state_nxt = DWSP_BUSY;
                            end
                        end
                        dwsp_pkg::DWSP_READ_NV, dwsp_pkg::DWSP_READ_WIPER:
                        begin
                            rb_word_nxt[23:16] = rx_r[23:16];
                            rb_word_nxt[15:0] = (cmd == dwsp_pkg::DWSP_READ_NV) ? nv_r[addr]
                                : {6'h00, wiper_r[ch]};
                            rb_mode_nxt = 1'b1;
                            busy_cnt_nxt = 20'(dwsp_pkg::READ_CYC);
                            state_nxt = DWSP_BUSY;
                        end
                        dwsp_pkg::DWSP_WRITE:
                        begin
                            if (wp_n_s && ch_ok)
                            begin
                                wiper_nxt[ch] = data[9:0];
                            end
                        end
                        dwsp_pkg::DWSP_NOP:
                        begin
                            rb_mode_nxt = 1'b0;
                        end
                        default:
                        begin
                            if (wp_n_s)
                            begin
                                if (is_all(cmd))
                                begin
                                    wiper_nxt[0] = step(wiper_r[0], cmd);
                                    wiper_nxt[1] = step(wiper_r[1], cmd);
                                end
                                else if (ch_ok)
                                begin
                                    wiper_nxt[ch] = step(wiper_r[ch], cmd);
                                end
                            end
                        end
                    endcase
                end
            end
            DWSP_BUSY:
            begin
                // Frames arriving now are dropped, which locks the input
                busy_cnt_nxt = busy_cnt_r - 20'h00001;
                if (busy_cnt_r <= 20'h00001)
                begin
                    state_nxt = DWSP_IDLE;
                end
            end
            DWSP_REFRESH_LOW:
            begin
                wiper_nxt[0] = dwsp_pkg::WIPER_MID;
                wiper_nxt[1] = dwsp_pkg::WIPER_MID;
                if (refresh_n_s)
                begin
                    wiper_nxt[0] = nv_r[dwsp_pkg::ADDR_WIPER_ONE][9:0];
                    wiper_nxt[1] = nv_r[dwsp_pkg::ADDR_WIPER_TWO][9:0];
                    busy_cnt_nxt = 20'(dwsp_pkg::REFRESH_CYC);
                    state_nxt = DWSP_BUSY;
                end
            end
            default:
            begin
                state_nxt = DWSP_IDLE;
            end
        endcase

        // Refresh overrides everything, even an unfinished store
        if (!refresh_n_s && refresh_prev_r && state_r != DWSP_REFRESH_LOW)
        begin
            wiper_nxt[0] = dwsp_pkg::WIPER_MID;
            wiper_nxt[1] = dwsp_pkg::WIPER_MID;
            state_nxt = DWSP_REFRESH_LOW;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= DWSP_IDLE;
            cs_prev_r <= 1'b1;
            refresh_prev_r <= 1'b1;
            last_pos_r <= 5'h00;
            last_edges_r <= 8'h00;
            wiper_r[0] <= dwsp_pkg::WIPER_MID;
            wiper_r[1] <= dwsp_pkg::WIPER_MID;
            for (int i = 0; i < dwsp_pkg::NV_WORDS; i++)
            begin
                nv_r[i] <= (i < 2) ? dwsp_pkg::NV_WIPER_RESET : dwsp_pkg::NV_USER_RESET;
            end
            busy_cnt_r <= 20'h00000;
            rb_word_r <= 24'h000000;
            rb_mode_r <= 1'b0;
            primed_r <= 1'b0;
            link_clr_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cs_prev_r <= cs_prev_nxt;
            refresh_prev_r <= refresh_prev_nxt;
            last_pos_r <= last_pos_nxt;
            last_edges_r <= last_edges_nxt;
            wiper_r <= wiper_nxt;
            nv_r <= nv_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            rb_word_r <= rb_word_nxt;
            rb_mode_r <= rb_mode_nxt;
            primed_r <= primed_nxt;
            link_clr_r <= link_clr_nxt;
        end
    end

    // Bit index within the current frame; readback needs no crossing of
    // its own since rb_word_r only changes while the host clock is idle
    logic [4:0] frame_pos;
    logic [5:0] pos_diff;

    always_comb
    begin
        pos_diff = {1'b0, pos_r} - {1'b0, last_pos_r};
        if (pos_r < last_pos_r)
        begin
            pos_diff = pos_diff + 6'h18;
        end
        frame_pos = pos_diff[4:0];
    end

    assign serial_out_out = rb_mode_r ? rb_word_r[5'h17 - frame_pos] : rx_r[23];
    assign serial_out_oe_out = !chip_select_n_in;
    assign ready_out = (state_r == DWSP_IDLE);
    assign wiper_one_out = wiper_r[0];
    assign wiper_two_out = wiper_r[1];
endmodule

// File: tb/dwsp_host_model.sv
`timescale 1ns/1ps
module dwsp_host_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // Clock idles low between frames; released line reads high
    task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] got);
        got = 24'h000000;
        #13;
        cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            sdi_out = word[23 - i];
            #40;
            got = {got[22:0], sdo_oe_in ? sdo_in : 1'b1};
            sclk_out = 1'b1;
            #40;
            sclk_out = 1'b0;
        end
        #40;
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule

// File: tb/dwsp_checker.sv
`timescale 1ns/1ps
module dwsp_checker #(
    parameter int STORE_CYCLES = 50,
    parameter int RELOAD_CYCLES = 20
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in,
    input wire logic write_protect_n_in,
    input wire logic hardware_refresh_n_in,
    input wire logic serial_out_out,
    input wire logic serial_out_oe_out,
    input wire logic ready_out,
    input wire logic [9:0] wiper_one_out,
    input wire logic [9:0] wiper_two_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_oe_follows_cs: assert property (serial_out_oe_out == !chip_select_n_in)
        else $error("serial output enable differs from chip select");
    a_stable_in_frame: assert property ((!chip_select_n_in && hardware_refresh_n_in) [*8]
        |-> $stable(wiper_one_out) && $stable(wiper_two_out))
        else $error("wiper moved while chip select low");
    a_change_cs_high: assert property (($changed(wiper_one_out) || $changed(wiper_two_out))
        && hardware_refresh_n_in && $past(hardware_refresh_n_in, 8) |-> chip_select_n_in)
        else $error("wiper changed with chip select low");
    a_busy_min_hold: assert property ($fell(ready_out) |-> !ready_out [*8])
        else $error("ready returned high too soon");
    a_busy_cause: assert property ($fell(ready_out)
        |-> (chip_select_n_in && $past(chip_select_n_in, 3)) || !hardware_refresh_n_in)
        else $error("ready fell without a command or refresh");
    a_refresh_mid: assert property (!hardware_refresh_n_in [*8]
        |-> wiper_one_out == dwsp_pkg::WIPER_MID && wiper_two_out == dwsp_pkg::WIPER_MID)
        else $error("wipers not midscale during refresh");
    a_refresh_busy: assert property ($fell(hardware_refresh_n_in) |-> ##[1:8] !ready_out)
        else $error("ready did not drop on refresh");
    a_refresh_rise_busy: assert property ($rose(hardware_refresh_n_in) |-> ##4 !ready_out [*8])
        else $error("ready high right after refresh release");
endmodule
bind dwsp_top dwsp_checker #(.STORE_CYCLES(STORE_CYCLES), .RELOAD_CYCLES(RELOAD_CYCLES))
    i_dwsp_checker (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .serial_clk_in(serial_clk_in),
    .chip_select_n_in(chip_select_n_in), .serial_in(serial_in),
    .write_protect_n_in(write_protect_n_in), .hardware_refresh_n_in(hardware_refresh_n_in),
    .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
    .ready_out(ready_out), .wiper_one_out(wiper_one_out), .wiper_two_out(wiper_two_out));

// File: tb/dwsp_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module dwsp_top_tb_top;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic write_protect_n_in = 1'b1;
    logic hardware_refresh_n_in = 1'b1;
    logic serial_clk_in, chip_select_n_in, serial_in;
    logic serial_out_out, serial_out_oe_out, ready_out;
    logic [9:0] wiper_one_out, wiper_two_out;
    logic [23:0] rx_word, prev_word;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    // Word sent, then wiper one and wiper two expected after it
    localparam logic [43:0] ROWS [12] = '{
        {24'hB00100, 10'h100, 10'h200}, {24'hB10155, 10'h100, 10'h155},
        {24'hE00000, 10'h101, 10'h155}, {24'h610000, 10'h101, 10'h154},
        {24'hF00000, 10'h102, 10'h155}, {24'h700000, 10'h101, 10'h154},
        {24'hC00000, 10'h202, 10'h154}, {24'h410000, 10'h202, 10'h0AA},
        {24'hD00000, 10'h3FF, 10'h154}, {24'h500000, 10'h1FF, 10'h0AA},
        {24'hB20123, 10'h1FF, 10'h0AA}, {24'h000000, 10'h1FF, 10'h0AA}};
    always #50 mclk_in = ~mclk_in;
    dwsp_top #(.STORE_CYCLES(50), .RELOAD_CYCLES(20)) i_dwsp_top (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .serial_clk_in(serial_clk_in),
        .chip_select_n_in(chip_select_n_in), .serial_in(serial_in),
        .write_protect_n_in(write_protect_n_in), .hardware_refresh_n_in(hardware_refresh_n_in),
        .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
        .ready_out(ready_out), .wiper_one_out(wiper_one_out), .wiper_two_out(wiper_two_out));
    dwsp_host_model i_dwsp_host_model (.sclk_out(serial_clk_in), .cs_n_out(chip_select_n_in),
        .sdi_out(serial_in), .sdo_in(serial_out_out), .sdo_oe_in(serial_out_oe_out));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #10;
    endtask
    task automatic frame(input logic [23:0] w);
        i_dwsp_host_model.xfer(w, 24, rx_word);
        tick(10);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        `CHK(ready_out, 1'b1)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    initial
    begin
        tick(5);
        `CHK(wiper_one_out, 10'h200)
        `CHK(wiper_two_out, 10'h200)
        `CHK(ready_out, 1'b1)
        sys_rst_in = 1'b0;
        tick(4);
        // First frame only aligns the link
        frame(24'h000000);
        prev_word = 24'h000000;
        for (int i = 0; i < 12; i++)
        begin
            frame(ROWS[i][43:20]);
            `CHK(rx_word, prev_word)
            `CHK(wiper_one_out, ROWS[i][19:10])
            `CHK(wiper_two_out, ROWS[i][9:0])
            prev_word = ROWS[i][43:20];
        end
        frame(24'hB00155);
        frame(24'h200000);
        `CHK(ready_out, 1'b0)
        frame(24'hB003FF);
        `CHK(wiper_one_out, 10'h155)
        wait_ready();
        `CHK(wiper_one_out, 10'h155)
        frame(24'h900000);
        `CHK(ready_out, 1'b0)
        wait_ready();
        frame(24'h000000);
        `CHK(rx_word, 24'h900155)
        frame(24'hA10000);
        wait_ready();
        frame(24'h000000);
        `CHK(rx_word, 24'hA100AA)
        frame(24'h35ABCD);
        `CHK(ready_out, 1'b0)
        wait_ready();
        frame(24'h950000);
        wait_ready();
        frame(24'h000000);
        `CHK(rx_word, 24'h95ABCD)
        frame(24'hB00300);
        frame(24'hB10111);
        write_protect_n_in = 1'b0;
        tick(6);
        frame(24'hB00000);
        `CHK(wiper_one_out, 10'h300)
        frame(24'h351234);
        `CHK(ready_out, 1'b1)
        frame(24'h100000);
        `CHK(wiper_one_out, 10'h155)
        frame(24'h800000);
        `CHK(ready_out, 1'b0)
        wait_ready();
        `CHK(wiper_two_out, 10'h200)
        frame(24'h000000);
        write_protect_n_in = 1'b1;
        tick(6);
        frame(24'hB00000);
        hardware_refresh_n_in = 1'b0;
        tick(12);
        `CHK(wiper_one_out, 10'h200)
        `CHK(ready_out, 1'b0)
        hardware_refresh_n_in = 1'b1;
        tick(10);
        `CHK(wiper_one_out, 10'h155)
        `CHK(wiper_two_out, 10'h200)
        wait_ready();
        // Short frame fails the bit count check and is dropped, so wiper one keeps its value
        i_dwsp_host_model.xfer(24'hB003FF, 12, rx_word);
        tick(10);
        `CHK(wiper_one_out, 10'h155)
        sys_rst_in = 1'b1;
        tick(5);
        sys_rst_in = 1'b0;
        tick(1);
        `CHK(wiper_one_out, 10'h200)
        `CHK(ready_out, 1'b1)
        wrap_up();
    end
endmodule
